// ---- dcs_ctrl_status.sv ----
// Control word decode and status word composition for a motor drive.
// Assumes drive flags are synchronous to CLK; Avalon-MM slave, 32-bit data.
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module dcs_ctrl_status #(
  parameter bit FIELDBUS_FITTED = 1'b1,
  parameter int FASTIO_CYCLES = dcs_pkg::FASTIO_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Drive condition flags
  input wire dcs_pkg::dcs_drive_flags_t DRIVE_FLAGS,
  input wire logic [4:0] RAW_INPUTS,
  // Decoded commands and status word
  output dcs_pkg::dcs_cmd_t CMD,
  output logic [15:0] STATUS_WORD
);
  logic [15:0] ctrl_reg;
  logic [2:0] config_reg;
  logic [15:0] status_reg, status_next;
  dcs_pkg::dcs_cmd_t cmd_reg, cmd_next;
  logic bit7_reg;
  logic start_dis_reg, start_dis_next;
  logic [4:0] fast_reg;
  logic [31:0] fast_cnt_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic wait_reg;

  // Offset compare shared by the read mux and the write strobes
  function automatic logic addr_is(input logic [3:0] addr,
    input logic [3:0] off);
    addr_is = addr == off;
  endfunction

  wire fieldbus = config_reg[dcs_pkg::CFG_PROFILE_POS] ==
    dcs_pkg::PROFILE_FIELDBUS;
  wire fast_mode = FIELDBUS_FITTED &&
    config_reg[dcs_pkg::CFG_FASTIO_POS];
  wire relay_cfg = config_reg[dcs_pkg::CFG_RELAY_POS];
  wire serial_ok = !DRIVE_FLAGS.local_stop &&
    !DRIVE_FLAGS.local_mode;
  // Local mode refuses the word just as a data-not-valid word does
  wire word_valid = ctrl_reg[10] && serial_ok;
  wire on_all = &ctrl_reg[2:0];
  wire access = AVS_READ || AVS_WRITE;
  wire hit_ctrl = addr_is(AVS_ADDRESS, dcs_pkg::OFF_CTRL);
  wire hit_cfg = addr_is(AVS_ADDRESS, dcs_pkg::OFF_CONFIG);
  wire hit_stat = addr_is(AVS_ADDRESS, dcs_pkg::OFF_STATUS);
  wire wr_ctrl = AVS_WRITE && !ack_reg && hit_ctrl;
  wire wr_cfg = AVS_WRITE && !ack_reg && hit_cfg;
  wire fast_tick = fast_cnt_reg >= 32'(FASTIO_CYCLES - 1);

  // Read mux; unmapped offsets return zero
  logic [31:0] rd_mux;
  always_comb
  begin
    if (hit_ctrl)
      rd_mux = {16'h0000, ctrl_reg};
    else if (hit_cfg)
      rd_mux = {29'h0000000, config_reg};
    else if (hit_stat)
      rd_mux = {16'h0000, status_reg};
    else
      rd_mux = 32'h00000000;
  end

  // Status word composition
  always_comb
  begin
    status_next = 16'h0000;
    status_next[2] = !DRIVE_FLAGS.coasting && !DRIVE_FLAGS.trip;
    status_next[3] = DRIVE_FLAGS.trip;
    status_next[6] = DRIVE_FLAGS.trip_lock;
    status_next[7] = DRIVE_FLAGS.warning || DRIVE_FLAGS.dc_volt_warn ||
      DRIVE_FLAGS.over_current || DRIVE_FLAGS.over_temp;
    status_next[8] = DRIVE_FLAGS.speed_eq_ref;
    status_next[9] = serial_ok;
    status_next[10] = !DRIVE_FLAGS.at_freq_limit;
    status_next[11] = DRIVE_FLAGS.start_signal ||
      DRIVE_FLAGS.freq_nonzero;
    status_next[13] = DRIVE_FLAGS.dc_volt_warn;
    status_next[14] = DRIVE_FLAGS.over_current;
    status_next[15] = DRIVE_FLAGS.over_temp;
    if (fieldbus)
    begin
      status_next[0] = on_all && DRIVE_FLAGS.ready;
      status_next[1] = DRIVE_FLAGS.ready;
      status_next[4] = !ctrl_reg[1];
      status_next[5] = !ctrl_reg[2];
      status_next[6] = start_dis_reg;
    end
    else
    begin
      status_next[0] = DRIVE_FLAGS.ready;
      status_next[1] = DRIVE_FLAGS.ready;
    end
    if (fast_mode)
    begin
      status_next[5] = fast_reg[0];
      status_next[12] = fast_reg[1];
      status_next[13] = fast_reg[2];
      status_next[14] = fast_reg[3];
      status_next[15] = fast_reg[4];
    end
  end

  // Command decode
  always_comb
  begin
    cmd_next = '0;
    cmd_next.relay_on = cmd_reg.relay_on;
    if (word_valid && fieldbus)
    begin
      cmd_next.ramp_stop = !on_all;
      cmd_next.jog1 = ctrl_reg[8];
      cmd_next.jog2 = ctrl_reg[9];
      cmd_next.slow_down = ctrl_reg[11];
      cmd_next.catch_up = ctrl_reg[12] && !ctrl_reg[11];
      cmd_next.trip_reset = ctrl_reg[7] && !bit7_reg;
    end
    // Relay drops as soon as the stop command is withdrawn
    cmd_next.relay_on = relay_cfg && cmd_next.ramp_stop &&
      !DRIVE_FLAGS.freq_nonzero;
  end

  // Start-disable latch: set events win over the clearing pattern
  always_comb
  begin
    start_dis_next = start_dis_reg;
    if (word_valid && !ctrl_reg[0] && ctrl_reg[1] && ctrl_reg[2])
      start_dis_next = 1'b0;
    if (cmd_next.trip_reset ||
        (word_valid && (!ctrl_reg[1] || !ctrl_reg[2])))
      start_dis_next = 1'b1;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_reg <= dcs_pkg::CTRL_RST;
      config_reg <= dcs_pkg::CONFIG_RST;
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else if (CE)
    begin
      ack_reg <= access && !ack_reg;
      // Own flop so the pin does not hang off an inverter
      wait_reg <= !(access && !ack_reg);
      if (AVS_READ && !ack_reg)
        rdata_reg <= rd_mux;
      if (wr_ctrl)
        ctrl_reg <= AVS_WRITEDATA[15:0];
      if (wr_cfg)
        config_reg <= AVS_WRITEDATA[2:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      status_reg <= 16'h0000;
      cmd_reg <= '0;
      bit7_reg <= 1'b0;
      start_dis_reg <= 1'b1;
    end
    else if (CE)
    begin
      status_reg <= status_next;
      cmd_reg <= cmd_next;
      // Edge history only advances on valid words so a held bit is no edge
      if (word_valid)
        bit7_reg <= ctrl_reg[7];
      start_dis_reg <= start_dis_next;
    end
  end

  // Raw inputs resampled every millisecond, well inside the 10 ms budget
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      fast_reg <= 5'h00;
      fast_cnt_reg <= 32'h00000000;
    end
    else if (CE)
    begin
      fast_cnt_reg <= fast_tick ? 32'h00000000 : fast_cnt_reg + 32'h1;
      if (fast_tick)
        fast_reg <= RAW_INPUTS;
    end
  end

  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign CMD = cmd_reg;
  assign STATUS_WORD = status_reg;

  AST_TRIP_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE |=> status_reg[3] == $past(DRIVE_FLAGS.trip))
    else $error("trip bit mismatch");
  AST_LOCK_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && !fieldbus |=> status_reg[6] == $past(DRIVE_FLAGS.trip_lock))
    else $error("trip lock bit mismatch");
  AST_SERIAL: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && DRIVE_FLAGS.local_mode |=> !status_reg[9] && !cmd_reg.jog1)
    else $error("local mode not refused");
  AST_BIT12: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && !fast_mode |=> !status_reg[12])
    else $error("bit 12 not zero");
  AST_PRIO: assert property (@(posedge CLK) disable iff (!RST_B)
    !(cmd_reg.slow_down && cmd_reg.catch_up))
    else $error("catch-up with slow-down");
  AST_RSTEDGE: assert property (@(posedge CLK) disable iff (!RST_B)
    cmd_reg.trip_reset |=> !cmd_reg.trip_reset)
    else $error("reset not one pulse");
  AST_INVALID: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && !ctrl_reg[10] |=> !cmd_reg.ramp_stop && !cmd_reg.jog2)
    else $error("invalid word acted on");
  AST_OFF2: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && fieldbus |=> status_reg[4] == !$past(ctrl_reg[1]))
    else $error("off2 bit mismatch");
  AST_RAMP: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && word_valid && fieldbus && !on_all |=> cmd_reg.ramp_stop)
    else $error("ramp stop missing");
  AST_BUS: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && access && !ack_reg |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  AST_COAST_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && (DRIVE_FLAGS.coasting || DRIVE_FLAGS.trip) |=> !status_reg[2])
    else $error("coast bit set while released");
  AST_UNUSED45: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && !fieldbus && !fast_mode |=> !status_reg[4] && !status_reg[5])
    else $error("native unused bits not zero");
  AST_WARN_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && DRIVE_FLAGS.warning |=> status_reg[7])
    else $error("warning bit missing");
  AST_SPEED_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE |=> status_reg[8] == $past(DRIVE_FLAGS.speed_eq_ref))
    else $error("speed bit mismatch");
  AST_LIMIT_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE |=> status_reg[10] == !$past(DRIVE_FLAGS.at_freq_limit))
    else $error("limit bit mismatch");
  AST_RUN_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE |=> status_reg[11] == ($past(DRIVE_FLAGS.start_signal) ||
    $past(DRIVE_FLAGS.freq_nonzero)))
    else $error("running bit mismatch");
  AST_VOLT_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && !fast_mode |=> status_reg[13] == $past(DRIVE_FLAGS.dc_volt_warn))
    else $error("voltage bit mismatch");
  AST_CURR_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && !fast_mode |=> status_reg[14] == $past(DRIVE_FLAGS.over_current))
    else $error("current bit mismatch");
  AST_TEMP_BIT: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && !fast_mode |=> status_reg[15] == $past(DRIVE_FLAGS.over_temp))
    else $error("thermal bit mismatch");
  AST_FAST_IN: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && fast_mode |=> status_reg[12] == $past(fast_reg[1]))
    else $error("fast input bit mismatch");
  AST_RELAY: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && !relay_cfg |=> !cmd_reg.relay_on)
    else $error("relay on without stop function");
  AST_JOG: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && word_valid && fieldbus |=> cmd_reg.jog1 == $past(ctrl_reg[8]) &&
    cmd_reg.jog2 == $past(ctrl_reg[9]))
    else $error("jog select mismatch");
  AST_SLOW: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && word_valid && fieldbus && ctrl_reg[11] |=> cmd_reg.slow_down)
    else $error("slow-down missing");
  AST_READY_OK: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && fieldbus |=> status_reg[0] == ($past(&ctrl_reg[2:0]) &&
    $past(DRIVE_FLAGS.ready)))
    else $error("control ready bit mismatch");
  AST_OFF3: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && fieldbus && !fast_mode |=> status_reg[5] == !$past(ctrl_reg[2]))
    else $error("off3 bit mismatch");
  AST_STARTDIS: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && cmd_next.trip_reset |=> start_dis_reg)
    else $error("start disable not set on reset");
  COV_RAMP: cover property (@(posedge CLK) cmd_reg.ramp_stop);
  COV_RELAY: cover property (@(posedge CLK) cmd_reg.relay_on);
  COV_RESET: cover property (@(posedge CLK) cmd_reg.trip_reset);
  COV_FAST: cover property (@(posedge CLK) fast_mode && fast_tick);
  COV_PRIO: cover property (@(posedge CLK)
    word_valid && ctrl_reg[11] && ctrl_reg[12]);
endmodule
`default_nettype wire

// ---- dcs_ctrl_status_test.sv ----
// Self-checking bench for the control and status word block.
// Assumes the flag model above; CE dropped once, fast-input period cut to 4.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, x) begin tests_run++; if ((a) !== (x)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, x); end end
module dcs_ctrl_status_test;
  localparam logic [15:0] CTL [3] = '{16'h1f07, 16'h1407, 16'h0087};
  localparam logic [6:0] CMX [3] = '{7'h38, 7'h04, 7'h00};
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [4:0] raw = 5'h00;
  logic [3:0] sel = 4'hd;
  logic ce = 1'b1;
  wire logic [31:0] rdata;
  wire logic waitreq;
  wire dcs_pkg::dcs_drive_flags_t flags;
  wire dcs_pkg::dcs_cmd_t cmd;
  wire logic [15:0] sw;
  logic [31:0] q;
  logic [15:0] e;
  int bad_count = 0;
  int tests_run = 0;
  int k;
  int c;
  initial
  begin
    forever #10 CLK = ~CLK;
  end
  dcs_ctrl_status #(.FIELDBUS_FITTED(1'b1), .FASTIO_CYCLES(4))
    dcs_ctrl_status_i (.CLK(CLK), .RST_B(RST_B), .CE(ce),
    .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .DRIVE_FLAGS(flags), .RAW_INPUTS(raw),
    .CMD(cmd), .STATUS_WORD(sw));
  dcs_flag_src dcs_flag_src_i (.CLK(CLK), .RST_B(RST_B), .SEL(sel),
    .FLAGS(flags));
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    addr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdata <= d;
    @(posedge CLK);
    while (waitreq !== 1'b0 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    // Read data is taken at the edge that sees waitrequest low
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (waitreq !== 1'b0)
    begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic setsel(input logic [3:0] s, input logic [4:0] r);
    @(posedge CLK);
    sel <= s;
    raw <= r;
    tick(10);
  endtask
  task automatic pulses();
    c = 0;
    repeat (4)
    begin
      @(negedge CLK);
      c += (cmd.trip_reset === 1'b1);
    end
  endtask
  // Flag index: 13 ready, 12 trip, 10 warning, 9 speed match,
  // 8/7 local, 6 limit, 5 start, 4 freq, 3 volt, 2 current, 1 temp, 0 coast
  function automatic logic [15:0] exp_sw(input logic [13:0] f);
    exp_sw = 16'h0000;
    exp_sw[2] = !f[0] && !f[12];
    exp_sw[3] = f[12];
    exp_sw[7] = f[10] | f[3] | f[2] | f[1];
    exp_sw[8] = f[9];
    exp_sw[9] = !(f[8] | f[7]);
    exp_sw[10] = !f[6];
    exp_sw[11] = f[5] | f[4];
    exp_sw[13] = f[3];
    exp_sw[14] = f[2];
    exp_sw[15] = f[1];
  endfunction
  initial
  begin
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    tick(2);
    `CHK(sw & 16'h0040, 16'h0040)
    bus(1'b1, dcs_pkg::OFF_CONFIG, 32'h4);
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h0406);
    tick(3);
    `CHK(sw & 16'h0071, 16'h0000)
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h0407);
    tick(3);
    `CHK(sw & 16'h0071, 16'h0001)
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h0400);
    tick(3);
    `CHK(sw & 16'h0071, 16'h0070)
    `CHK(cmd, 7'h41)
    for (k = 0; k < 3; k++)
    begin
      bus(1'b1, dcs_pkg::OFF_CTRL, {16'h0, CTL[k]});
      tick(3);
      `CHK(cmd, CMX[k])
    end
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h0407);
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h0487);
    pulses();
    `CHK(c, 1)
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h0487);
    pulses();
    `CHK(c, 0)
    for (k = 0; k < 14; k++)
    begin
      setsel(k[3:0], 5'h00);
      e = exp_sw(14'h2000 | (14'h0001 << k));
      `CHK(sw[7:0] & 8'h8c, e[7:0])
      `CHK(sw[11:8], e[11:8])
      `CHK(sw[15:12], e[15:12])
    end
    setsel(4'h7, 5'h00);
    bus(1'b1, dcs_pkg::OFF_CTRL, 32'h0400);
    tick(3);
    `CHK(cmd, 7'h00)
    bus(1'b1, dcs_pkg::OFF_CONFIG, 32'h2);
    setsel(4'hd, 5'h15);
    `CHK(sw & 16'hf020, 16'ha020)
    setsel(4'hd, 5'h0a);
    `CHK(sw & 16'hf020, 16'h5000)
    bus(1'b1, dcs_pkg::OFF_CONFIG, 32'h1);
    setsel(4'hb, 5'h00);
    `CHK(sw & 16'h0070, 16'h0040)
    bus(1'b0, dcs_pkg::OFF_STATUS, 32'h0);
    `CHK(q[15:0] & 16'h0070, 16'h0040)
    bus(1'b0, dcs_pkg::OFF_CTRL, 32'h0);
    `CHK(q, 32'h0000_0400)
    bus(1'b0, dcs_pkg::OFF_REF, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, dcs_pkg::OFF_CONFIG, 32'h0);
    `CHK(q, 32'h1)
    // Clock enable low must freeze the status word against flag changes
    @(posedge CLK);
    ce <= 1'b0;
    sel <= 4'h3;
    tick(6);
    `CHK(sw & 16'h2040, 16'h0040)
    @(posedge CLK);
    ce <= 1'b1;
    tick(3);
    `CHK(sw & 16'h2040, 16'h2000)
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- dcs_flag_src.sv ----
// Model of the drive core that feeds condition flags to the block.
// Assumes the bench selects one active condition at a time.
`timescale 1ns/100ps
`default_nettype none
module dcs_flag_src (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Condition select; 13 leaves only the ready flag up
  input wire logic [3:0] SEL,
  // Flags to the block
  output var dcs_pkg::dcs_drive_flags_t FLAGS
);
  wire logic [13:0] flag_next = 14'h2000 | (14'h0001 << SEL);
  // Registered, so flags move on clock edges as the real core's do
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      FLAGS <= '0;
    else
      FLAGS <= flag_next;
  end
endmodule
`default_nettype wire

// ---- dcs_pkg.sv ----
// Package for the drive control/status word logic.
// Assumes a single 50 MHz system clock domain.
package dcs_pkg;
  // Register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CONFIG = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_REF = 4'hc;
  // Config field positions
  localparam int CFG_PROFILE_POS = 0;
  localparam int CFG_FASTIO_POS = 1;
  localparam int CFG_RELAY_POS = 2;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [2:0] CONFIG_RST = 3'h0;
  // Profile codes: fieldbus profile is value 0
  localparam logic PROFILE_FIELDBUS = 1'b0;
  // Fast-input refresh time and its cycle count
  localparam int CLK_HZ = 50000000;
  localparam int FASTIO_MS = 10;
  localparam int FASTIO_CYC = FASTIO_MS * (CLK_HZ / 1000);
  localparam int FASTIO_PERIOD_NS = 1000000;
  localparam int FASTIO_SAMPLE_CYC = FASTIO_PERIOD_NS / 20;

  typedef struct packed {
    logic ready;
    logic trip;
    logic trip_lock;
    logic warning;
    logic speed_eq_ref;
    logic local_stop;
    logic local_mode;
    logic at_freq_limit;
    logic start_signal;
    logic freq_nonzero;
    logic dc_volt_warn;
    logic over_current;
    logic over_temp;
    logic coasting;
  } dcs_drive_flags_t;

  typedef struct packed {
    logic ramp_stop;
    logic jog1;
    logic jog2;
    logic slow_down;
    logic catch_up;
    logic trip_reset;
    logic relay_on;
  } dcs_cmd_t;
endpackage
